// ==== design/psrc_defines.vh ====
`ifndef PSRC_DEFINES_VH
`define PSRC_DEFINES_VH
// Register addresses
`define PSRC_ADDR_SEL 16'h2072
`define PSRC_ADDR_TIM 16'h2872
`define PSRC_ADDR_PCS 16'h3072
// Select register field positions
`define PSRC_B_MREF 15
`define PSRC_B_VREF 14
`define PSRC_B_CBR 13
`define PSRC_B_CBRSR 12
`define PSRC_B_SCSI 11
`define PSRC_PAR_HI 10
`define PSRC_PAR_LO 9
`define PSRC_B_PARL 8
`define PSRC_SERA_HI 7
`define PSRC_SERA_LO 5
`define PSRC_B_SERAL 4
`define PSRC_SERB_HI 3
`define PSRC_SERB_LO 1
`define PSRC_B_SERBL 0
// Timing register field positions
`define PSRC_B_RTCL 15
`define PSRC_B_FVGA 14
`define PSRC_B_ENPCS 12
`define PSRC_B_UMSK 11
`define PSRC_LMSK_HI 10
`define PSRC_LMSK_LO 8
`define PSRC_B_PRGL 7
// Reset values
`define PSRC_RST16 16'h0000
// Chip select codes
`define PSRC_CS_SERA 5'h0E
`define PSRC_CS_PAR 5'h0F
`define PSRC_CS_SERB 5'h10
`define PSRC_CS_PROG 5'h11
`define PSRC_CS_SCSI 5'h12
`define PSRC_CS_NONE 5'h1F
// Refresh divide, slow refresh and powerdown tick divide
`define PSRC_SLOW_DIV 3'h7
// Normal refresh period of 15 us in ns, and derived cycles at 10 ns
`define PSRC_REF_NS 15000
`define PSRC_CLK_NS 10
`define PSRC_REF_CYC (`PSRC_REF_NS / `PSRC_CLK_NS)
`define PSRC_VREF_NS 15000
`define PSRC_VREF_CYC (`PSRC_VREF_NS / `PSRC_CLK_NS)
// Down-counter reload values, one refresh period minus one
`define PSRC_REF_LOAD 16'h05DB
`define PSRC_VREF_LOAD 16'h05DB
`endif

// ==== design/psrc_ctl.v ====
// Contract
// - Slow main refresh divides rate by eight
// - Full powerdown slow: refresh every eighth tick
// - Slow video refresh lengthens video period
// - CAS-before-RAS refresh selection bit
// - Self refresh holds CAS low in suspend
// - SCSI chip select 12 at 353X
// - Parallel field places chip select 0F
// - Parallel bus location bit
// - Serial A field places chip select 0E
// - Serial A bus location bit
// - Serial B field places chip select 10
// - Serial B bus location bit
// - Clock chip bus location bit; held in the timing register but drives no output
// - Fast video: one wait state 3C0-3CF
// - Programmable chip select from bits 12-7
// - Chip select output as five-bit code
`timescale 1ns/1ns
`include "psrc_defines.vh"
`default_nettype none
module psrc_ctl (
  input wire i_clk,
  input wire i_rst_n,
  input wire [15:0] i_io_addr,
  input wire [15:0] i_io_wdata,
  input wire i_io_wr,
  input wire i_io_rd,
  input wire i_full_powerdown_bit,
  input wire i_suspend,
  input wire i_powerdown_refresh_tick,
  output reg [15:0] o_io_rdata,
  output reg o_io_rd_hit,
  output reg [4:0] o_select_code_lines,
  output reg o_select_valid,
  output reg o_select_on_expansion,
  output reg o_fast_video_wait,
  output reg o_main_refresh_req,
  output reg o_video_refresh_req,
  output reg o_cas_first_refresh,
  output reg o_cas_hold_low_n
);

  // Software-visible registers
  reg [15:0] sel_reg;
  reg [15:0] tim_reg;
  reg [15:0] pcs_reg;
  // Synchronised powerdown tick and its edge history
  reg [2:0] tick_sync_reg;
  // Powerdown tick counter, wraps every eighth synchronised rise
  reg [2:0] pd_cnt_reg;
  // Main refresh period down-counter and slow-mode divider
  reg [15:0] mref_cnt_reg;
  reg [2:0] mslow_cnt_reg;
  // Video refresh period down-counter and slow-mode divider
  reg [15:0] vref_cnt_reg;
  reg [2:0] vslow_cnt_reg;
  // Synchronised control inputs
  reg [1:0] fpd_sync_reg;
  reg [1:0] susp_sync_reg;

  // Fixed serial range decode, shared by both serial ports
  // Serial ports span eight bytes, so only A9..A3 take part
  function serial_hit;
    input [2:0] code;
    input [15:0] addr;
    begin
      case (code)
        3'h1: serial_hit = (addr[9:3] == 7'h7F);
        3'h2: serial_hit = (addr[9:3] == 7'h5F);
        3'h3: serial_hit = (addr[9:3] == 7'h7D);
        3'h4: serial_hit = (addr[9:3] == 7'h5D);
        default: serial_hit = 1'b0; // Codes 101-111 give nothing
      endcase
    end
  endfunction

  // Field slices of the select and timing registers
  wire [1:0] par_code = sel_reg[`PSRC_PAR_HI:`PSRC_PAR_LO];
  wire [2:0] sera_code = sel_reg[`PSRC_SERA_HI:`PSRC_SERA_LO];
  wire [2:0] serb_code = sel_reg[`PSRC_SERB_HI:`PSRC_SERB_LO];
  wire [2:0] lmsk = tim_reg[`PSRC_LMSK_HI:`PSRC_LMSK_LO];
  // Combinational decode results
  reg par_hit;
  reg pcs_hit;
  reg [15:0] pcs_mask;
  wire sera_hit = serial_hit(sera_code, i_io_addr);
  wire serb_hit = serial_hit(serb_code, i_io_addr);
  wire scsi_hit = sel_reg[`PSRC_B_SCSI] && (i_io_addr[15:4] == 12'h353);
  wire vga_hit = (i_io_addr[9:4] == 6'h3C);
  wire io_cyc = i_io_wr | i_io_rd;

  // Parallel decode and programmable select mask
  always @*
  begin
    case (par_code)
      2'h1: par_hit = (i_io_addr[9:2] == 8'hEF);
      2'h2: par_hit = (i_io_addr[9:3] == 7'h6F);
      2'h3: par_hit = (i_io_addr[9:3] == 7'h4F);
      default: par_hit = 1'b0;
    endcase
    // Upper bits only count when enabled; low bits masked by code
    // A mask bit of zero drops that address bit from the compare
    pcs_mask = 16'h03FF;
    if (tim_reg[`PSRC_B_UMSK])
      pcs_mask = 16'hFFFF;
    case (lmsk)
      3'h1: pcs_mask = pcs_mask & 16'hFFFE;
      3'h2: pcs_mask = pcs_mask & 16'hFFFC;
      3'h3: pcs_mask = pcs_mask & 16'hFFF8;
      3'h4: pcs_mask = pcs_mask & 16'hFFF0;
      default: pcs_mask = pcs_mask;
    endcase
    pcs_hit = tim_reg[`PSRC_B_ENPCS] &&
      (((i_io_addr ^ pcs_reg) & pcs_mask) == 16'h0000);
  end

  // Register writes; all fields clear at reset
  // Only an exact 16-bit port match writes, so no alias can corrupt a field
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sel_reg <= `PSRC_RST16;
      tim_reg <= `PSRC_RST16;
      pcs_reg <= `PSRC_RST16;
    end
    else if (i_io_wr)
    begin
      if (i_io_addr == `PSRC_ADDR_SEL)
        sel_reg <= i_io_wdata;
      if (i_io_addr == `PSRC_ADDR_TIM)
        tim_reg <= i_io_wdata;
      if (i_io_addr == `PSRC_ADDR_PCS)
        pcs_reg <= i_io_wdata;
    end
  end

  // Registered read data; unmapped ports return zero without a hit
  // Reads have no side effects, so a stray read strobe is harmless
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_io_rdata <= `PSRC_RST16;
      o_io_rd_hit <= 1'b0;
    end
    else
    begin
      o_io_rd_hit <= i_io_rd && ((i_io_addr == `PSRC_ADDR_SEL) ||
        (i_io_addr == `PSRC_ADDR_TIM) || (i_io_addr == `PSRC_ADDR_PCS));
      if (i_io_rd && i_io_addr == `PSRC_ADDR_SEL)
        o_io_rdata <= sel_reg;
      else if (i_io_rd && i_io_addr == `PSRC_ADDR_TIM)
        o_io_rdata <= tim_reg;
      else if (i_io_rd && i_io_addr == `PSRC_ADDR_PCS)
        o_io_rdata <= pcs_reg;
      else
        o_io_rdata <= `PSRC_RST16;
    end
  end

  // Chip select encoder, registered one cycle after the I/O address
  // The register costs a cycle of latency but keeps the select lines
  // free of decode glitches as the address settles
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_select_code_lines <= `PSRC_CS_NONE;
      o_select_valid <= 1'b0;
      o_select_on_expansion <= 1'b0;
      o_fast_video_wait <= 1'b0;
    end
    else
    begin
      o_select_valid <= io_cyc && (sera_hit | serb_hit | par_hit | scsi_hit | pcs_hit);
      o_fast_video_wait <= io_cyc && vga_hit && tim_reg[`PSRC_B_FVGA];
      // Fixed selects win over the programmable one; A wins over B on overlap
      // Without a strobe the code idles, so a parked address selects nothing
      if (!io_cyc)
      begin
        o_select_code_lines <= `PSRC_CS_NONE;
        o_select_on_expansion <= 1'b0;
      end
      else if (sera_hit)
      begin
        o_select_code_lines <= `PSRC_CS_SERA;
        o_select_on_expansion <= sel_reg[`PSRC_B_SERAL];
      end
      else if (serb_hit)
      begin
        o_select_code_lines <= `PSRC_CS_SERB;
        o_select_on_expansion <= sel_reg[`PSRC_B_SERBL];
      end
      else if (par_hit)
      begin
        o_select_code_lines <= `PSRC_CS_PAR;
        o_select_on_expansion <= sel_reg[`PSRC_B_PARL];
      end
      // SCSI has no bus location bit; it always sits on the expansion bus
      else if (scsi_hit)
      begin
        o_select_code_lines <= `PSRC_CS_SCSI;
        o_select_on_expansion <= 1'b1;
      end
      else if (pcs_hit)
      begin
        o_select_code_lines <= `PSRC_CS_PROG;
        o_select_on_expansion <= tim_reg[`PSRC_B_PRGL];
      end
      else
      begin
        o_select_code_lines <= `PSRC_CS_NONE;
        o_select_on_expansion <= 1'b0;
      end
    end
  end

  // Input synchronisers for pin-level controls and the tick
  // Two stages guard against metastability on the asynchronous pins
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tick_sync_reg <= 3'h0;
      fpd_sync_reg <= 2'h0;
      susp_sync_reg <= 2'h0;
    end
    else
    begin
      tick_sync_reg <= {tick_sync_reg[1:0], i_powerdown_refresh_tick};
      fpd_sync_reg <= {fpd_sync_reg[0], i_full_powerdown_bit};
      susp_sync_reg <= {susp_sync_reg[0], i_suspend};
    end
  end

  // Edge detect reads only the second and third stages
  wire tick_rise = tick_sync_reg[1] & ~tick_sync_reg[2];
  wire full_powerdown_bit = fpd_sync_reg[1];
  wire slow_main = sel_reg[`PSRC_B_MREF];
  wire slow_video = sel_reg[`PSRC_B_VREF];
  wire mref_wrap = (mref_cnt_reg == 16'h0000);
  wire vref_wrap = (vref_cnt_reg == 16'h0000);

  // Refresh request timers; slow modes skip seven of eight periods
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mref_cnt_reg <= 16'h0000;
      mslow_cnt_reg <= 3'h0;
      vref_cnt_reg <= 16'h0000;
      vslow_cnt_reg <= 3'h0;
      pd_cnt_reg <= 3'h0;
      o_main_refresh_req <= 1'b0;
      o_video_refresh_req <= 1'b0;
    end
    else
    begin
      // Timers free-run, so a mode change only takes effect at the next wrap, or at the next tick rise when main refresh goes tick-paced
      mref_cnt_reg <= mref_wrap ? `PSRC_REF_LOAD : mref_cnt_reg - 16'h0001;
      vref_cnt_reg <= vref_wrap ? `PSRC_VREF_LOAD : vref_cnt_reg - 16'h0001;
      if (mref_wrap)
        mslow_cnt_reg <= mslow_cnt_reg + 3'h1;
      if (vref_wrap)
        vslow_cnt_reg <= vslow_cnt_reg + 3'h1;
      if (tick_rise)
        pd_cnt_reg <= pd_cnt_reg + 3'h1;
      // Full powerdown with slow main refresh paces main refresh from the slow external tick
      if (full_powerdown_bit && slow_main)
        o_main_refresh_req <= tick_rise && (pd_cnt_reg == `PSRC_SLOW_DIV);
      else if (slow_main)
        o_main_refresh_req <= mref_wrap && (mslow_cnt_reg == `PSRC_SLOW_DIV);
      else
        o_main_refresh_req <= mref_wrap;
      // Video refresh ignores the tick and follows its own timer
      if (slow_video)
        o_video_refresh_req <= vref_wrap && (vslow_cnt_reg == `PSRC_SLOW_DIV);
      else
        o_video_refresh_req <= vref_wrap;
    end
  end

  // Refresh style and self-refresh CAS hold
  // Registered so CAS does not glitch while suspend settles
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_cas_first_refresh <= 1'b0;
      o_cas_hold_low_n <= 1'b1;
    end
    else
    begin
      o_cas_first_refresh <= sel_reg[`PSRC_B_CBR];
      o_cas_hold_low_n <= ~(sel_reg[`PSRC_B_CBRSR] & susp_sync_reg[1]);
    end
  end

  // Clock chip placement is a static level from the register
  // No clock chip select is decoded in this block; the level drives no
  // output port, so no bus steering outside it can use it
  wire rtc_on_expansion = tim_reg[`PSRC_B_RTCL];
  wire unused_ok = rtc_on_expansion;

endmodule // psrc_ctl
`default_nettype wire

// ==== test/psrc_ctl_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "psrc_defines.vh"
// Port-level checks of the register, select, refresh and CAS behaviour
module psrc_ctl_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_io_addr,
  input wire logic [15:0] i_io_wdata,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic i_suspend,
  input wire logic [15:0] o_io_rdata,
  input wire logic o_io_rd_hit,
  input wire logic [4:0] o_select_code_lines,
  input wire logic o_select_valid,
  input wire logic o_fast_video_wait,
  input wire logic o_main_refresh_req,
  input wire logic o_video_refresh_req,
  input wire logic o_cas_hold_low_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Any of the three mapped register ports
  wire reg_hit = i_io_addr == `PSRC_ADDR_SEL || i_io_addr == `PSRC_ADDR_TIM
    || i_io_addr == `PSRC_ADDR_PCS;
  a_rd_hit_mapped: assert property (i_io_rd && reg_hit |=> o_io_rd_hit)
    else $error("read of mapped port gave no hit");
  a_rd_miss_quiet: assert property (i_io_rd && !reg_hit |=> !o_io_rd_hit && o_io_rdata == 16'h0000)
    else $error("read of unmapped port answered");
  a_wr_read_back: assert property (i_io_wr && i_io_addr == `PSRC_ADDR_SEL ##1 !i_io_wr ##1
    (i_io_rd && i_io_addr == `PSRC_ADDR_SEL) |=> o_io_rdata == $past(i_io_wdata, 3))
    else $error("select register read back differs");
  a_sel_no_strobe: assert property (!i_io_rd && !i_io_wr |=> !o_select_valid)
    else $error("chip select without strobe");
  a_idle_code_none: assert property (!o_select_valid |-> o_select_code_lines == 5'h1F)
    else $error("code not idle without select");
  a_main_pulse_gap: assert property ($rose(o_main_refresh_req) |=> !o_main_refresh_req [*8])
    else $error("main refresh pulses too close");
  a_video_pulse_gap: assert property ($rose(o_video_refresh_req) |=> !o_video_refresh_req [*8])
    else $error("video refresh pulses too close");
  a_cas_awake_high: assert property (!i_suspend [*5] |-> o_cas_hold_low_n)
    else $error("cas held low outside suspend");
  a_fvga_cause: assert property (o_fast_video_wait |-> $past(i_io_addr[9:4]) == 6'h3C
    && $past(i_io_rd || i_io_wr))
    else $error("fast video wait without video port cycle");
  c_select: cover property (o_select_valid);
  c_refresh: cover property (o_main_refresh_req);
  c_selfref: cover property (!o_cas_hold_low_n);
endmodule // psrc_ctl_chk
bind psrc_ctl psrc_ctl_chk i_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_io_addr(i_io_addr),
  .i_io_wdata(i_io_wdata), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_suspend(i_suspend),
  .o_io_rdata(o_io_rdata), .o_io_rd_hit(o_io_rd_hit), .o_select_code_lines(o_select_code_lines),
  .o_select_valid(o_select_valid), .o_fast_video_wait(o_fast_video_wait),
  .o_main_refresh_req(o_main_refresh_req), .o_video_refresh_req(o_video_refresh_req),
  .o_cas_hold_low_n(o_cas_hold_low_n));
`default_nettype wire

// ==== test/psrc_periph.sv ====
`timescale 1ns/1ns
`default_nettype none
// Peripheral chips: each bus latches the code that selects it, idle 1F otherwise
module psrc_periph (
  input wire logic i_clk,
  input wire logic [4:0] i_code,
  input wire logic i_valid,
  input wire logic i_exp,
  output logic [4:0] o_loc_code,
  output logic [4:0] o_exp_code
);
  // A device that is not selected sees nothing, so the idle code is shown
  always_ff @(posedge i_clk)
  begin
    o_loc_code <= (i_valid && !i_exp) ? i_code : 5'h1F;
    o_exp_code <= (i_valid && i_exp) ? i_code : 5'h1F;
  end
endmodule // psrc_periph
`default_nettype wire

// ==== test/psrc_ctl_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "psrc_defines.vh"
module psrc_ctl_tb;
  typedef struct {logic [15:0] cfg; logic [15:0] adr; logic [4:0] cs; logic ex;} psrc_row_t;
  logic i_clk = 0, i_rst_n = 0, i_io_wr = 0, i_io_rd = 0, i_fpd = 0, i_susp = 0, i_tick = 0;
  logic [15:0] i_io_addr = 0, i_io_wdata = 0;
  wire [15:0] rdata;
  wire [4:0] code, ploc, pexp;
  wire hit, vld, onexp, fvw, mreq, vreq, cbr, hold_n;
  int error_cnt = 0, checked = 0, cyc = 0;
  // Software never gives both serial fields one range
  psrc_row_t rows [17] = '{'{16'h0020, 16'h03F8, 5'h0E, 0}, '{16'h0050, 16'h12F8, 5'h0E, 1},
    '{16'h0060, 16'h03EF, 5'h0E, 0}, '{16'h0080, 16'h02E8, 5'h0E, 0},
    '{16'h00A0, 16'h03F8, 5'h1F, 0}, '{16'h0003, 16'h03FF, 5'h10, 1},
    '{16'h0004, 16'h02F8, 5'h10, 0}, '{16'h0006, 16'h03E8, 5'h10, 0},
    '{16'h0008, 16'h02EF, 5'h10, 0}, '{16'h000E, 16'h02E8, 5'h1F, 0},
    '{16'h0200, 16'h03BC, 5'h0F, 0}, '{16'h0500, 16'h037F, 5'h0F, 1},
    '{16'h0600, 16'h0278, 5'h0F, 0}, '{16'h0000, 16'h0378, 5'h1F, 0},
    '{16'h0800, 16'h3530, 5'h12, 1}, '{16'h0800, 16'h2530, 5'h1F, 0},
    '{16'h0020, 16'h03F0, 5'h1F, 0}};
  psrc_ctl i_psrc_ctl (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_io_addr(i_io_addr),
    .i_io_wdata(i_io_wdata), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_full_powerdown_bit(i_fpd),
    .i_suspend(i_susp), .i_powerdown_refresh_tick(i_tick), .o_io_rdata(rdata), .o_io_rd_hit(hit),
    .o_select_code_lines(code), .o_select_valid(vld), .o_select_on_expansion(onexp),
    .o_fast_video_wait(fvw), .o_main_refresh_req(mreq), .o_video_refresh_req(vreq),
    .o_cas_first_refresh(cbr), .o_cas_hold_low_n(hold_n));
  psrc_periph i_psrc_periph (.i_clk(i_clk), .i_code(code), .i_valid(vld), .i_exp(onexp),
    .o_loc_code(ploc), .o_exp_code(pexp));
  always #5 i_clk = ~i_clk;
  // Fast stand-in for the powerdown tick keeps the run short; cycle ceiling cuts hangs
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    i_tick <= (cyc % 20) < 10;
    if (cyc == 90000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (error_cnt == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // One I/O cycle; outputs are settled when it returns
  task automatic acc(input logic [15:0] a, input logic [15:0] d, input logic r, input logic w);
    @(posedge i_clk);
    i_io_addr <= a;
    i_io_wdata <= d;
    i_io_rd <= r;
    i_io_wr <= w;
    @(posedge i_clk);
    i_io_rd <= 0;
    i_io_wr <= 0;
    #1;
  endtask
  // One read cycle to a port, then the select code, valid and bus it gave
  task automatic sel_chk(input logic [15:0] a, input logic [4:0] cs, input logic ex);
    acc(a, 0, 1, 0);
    cmp("code", cs, code);
    cmp("valid", cs != 5'h1F, vld);
    if (cs != 5'h1F)
      cmp("bus", ex, onexp);
  endtask
  // Interval between two refresh pulses of one kind
  task automatic per(input bit v, input int e);
    int n;
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      do begin @(posedge i_clk); #1; n++; end while (!(v ? vreq : mreq) && n < 20000);
    end
    cmp(v ? "video period" : "main period", e[15:0], n[15:0]);
  endtask
  initial
  begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1;
    acc(`PSRC_ADDR_SEL, 0, 1, 0);
    cmp("sel reset", 16'h0000, rdata);
    acc(`PSRC_ADDR_TIM, 0, 1, 0);
    cmp("tim reset", 16'h0000, rdata);
    foreach (rows[i])
    begin
      acc(`PSRC_ADDR_SEL, rows[i].cfg, 0, 1);
      acc(`PSRC_ADDR_SEL, 0, 1, 0);
      cmp("sel read", rows[i].cfg, rdata);
      acc(rows[i].adr, 0, 1, 0);
      cmp("code", rows[i].cs, code);
      cmp("valid", rows[i].cs != 5'h1F, vld);
      if (rows[i].cs != 5'h1F) cmp("bus", rows[i].ex, onexp);
      @(posedge i_clk);
      #1;
      cmp("periph", rows[i].cs, rows[i].ex ? pexp : ploc);
    end
    acc(16'h2073, 16'hFFFF, 0, 1);
    acc(16'h2073, 0, 1, 0);
    cmp("unmapped hit", 0, hit);
    acc(`PSRC_ADDR_SEL, 0, 1, 0);
    cmp("sel kept", 16'h0020, rdata);
    acc(`PSRC_ADDR_TIM, 16'hC000, 0, 1);
    acc(`PSRC_ADDR_TIM, 0, 1, 0);
    cmp("tim read", 16'hC000, rdata);
    acc(16'h03C5, 0, 1, 0);
    cmp("fast video", 1, fvw);
    acc(16'h03D0, 0, 1, 0);
    cmp("slow video", 0, fvw);
    // Programmable select: two low bits masked, upper bits ignored, then included
    acc(`PSRC_ADDR_PCS, 16'h0230, 0, 1);
    acc(`PSRC_ADDR_TIM, 16'h1280, 0, 1);
    sel_chk(16'h5233, 5'h11, 1);
    sel_chk(16'h0234, 5'h1F, 0);
    acc(`PSRC_ADDR_TIM, 16'h1A00, 0, 1);
    sel_chk(16'h5233, 5'h1F, 0);
    sel_chk(16'h0231, 5'h11, 0);
    // A fixed serial select suppresses an overlapping programmable one
    acc(`PSRC_ADDR_PCS, 16'h03F8, 0, 1);
    sel_chk(16'h03F9, 5'h0E, 0);
    acc(`PSRC_ADDR_SEL, 16'h3000, 0, 1);
    @(posedge i_clk) i_susp <= 1;
    repeat (6) @(posedge i_clk);
    #1;
    cmp("cbr", 1, cbr);
    cmp("cas low", 0, hold_n);
    @(posedge i_clk) i_susp <= 0;
    // Mid-run reset clears every field again
    @(posedge i_clk) i_rst_n <= 0;
    @(posedge i_clk) i_rst_n <= 1;
    acc(`PSRC_ADDR_SEL, 0, 1, 0);
    cmp("sel cleared", 16'h0000, rdata);
    acc(`PSRC_ADDR_TIM, 0, 1, 0);
    cmp("tim cleared", 16'h0000, rdata);
    acc(`PSRC_ADDR_SEL, 16'h0000, 0, 1);
    per(0, 1500);
    per(1, 1500);
    acc(`PSRC_ADDR_SEL, 16'hC000, 0, 1);
    per(0, 12000);
    per(1, 12000);
    // Let the last slow pulse age past the gap check before the tick takes over
    repeat (10) @(posedge i_clk);
    i_fpd <= 1;
    per(0, 160);
    report_and_stop();
  end
endmodule // psrc_ctl_tb
`default_nettype wire
